//--- design/asrc_defs.svh
`ifndef ASRC_DEFS_SVH
`define ASRC_DEFS_SVH
// timing figures in ns, and cycle counts derived at a 100 ns clock period
`define ASRC_CLK_NS 100
`define ASRC_ACCESS_NS 10
`define ASRC_HOLD_NS 3
`define ASRC_FLOAT_NS 6
`define ASRC_PDOWN_NS 10
`define ASRC_CSW_NS 10
`define ASRC_ADDRW_NS 10
`define ASRC_DATAW_NS 7
// least times round up, at least one cycle
`define ASRC_CEIL(ns) (((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS)
`define ASRC_ACCESS_CYC `ASRC_CEIL(`ASRC_ACCESS_NS)
`define ASRC_FLOAT_CYC `ASRC_CEIL(`ASRC_FLOAT_NS)
`define ASRC_PDOWN_CYC `ASRC_CEIL(`ASRC_PDOWN_NS)
`define ASRC_WPULSE_CYC `ASRC_CEIL(`ASRC_CSW_NS)
`define ASRC_DSETUP_CYC `ASRC_CEIL(`ASRC_DATAW_NS)
`define ASRC_ADDR_W 12
`define ASRC_DATA_W 4
`define ASRC_CNT_W 3
`endif

//--- design/asrc_pkg.sv
package asrc_pkg;
   typedef logic [11:0] asrc_addr_t;
   typedef logic [3:0] asrc_data_t;
   typedef enum logic [2:0] {
      ASRC_IDLE = 3'b000,
      ASRC_RSEL = 3'b001,
      ASRC_RWAIT = 3'b010,
      ASRC_WSET = 3'b011,
      ASRC_WPULSE = 3'b100,
      ASRC_WEND = 3'b101,
      ASRC_GAP = 3'b110
   } asrc_state_t;
endpackage

//--- design/asrc_timer.sv
`include "asrc_defs.svh"
module asrc_timer
   import asrc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [`ASRC_CNT_W-1:0] count,
   output logic done
);
   logic [`ASRC_CNT_W-1:0] cnt_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 3'h0;
      end else if (load) begin
         cnt_r <= count;
      end else if (cnt_r != 3'h0) begin
         cnt_r <= cnt_r - 3'h1;
      end
   end
   // done ignores load: callers load on done, which would close a combinational loop
   assign done = (cnt_r == 3'h0);
endmodule // asrc_timer

//--- design/asrc_host.sv
// Behaviour
// (R1) read data is valid 10 ns after select falls with address stable
// (R2) device holds old data 3 ns after address change
// (R3) device outputs leave float no sooner than 3 ns after select
// (R4) device floats outputs within 6 ns after select rises
// (R5) device powers up at select fall, powers down 10 ns after rise
// (R6) host holds select low at least 10 ns before write end
// (R7) host sets address 10 ns before write end, holds it through end
// (R8) host drives write data 7 ns before write end, may drop after
// (R9) host keeps strobe or select high while address changes
// (R10) write-through outputs follow new write data within 10 ns
// (R11) write-through outputs show write data 10 ns after strobe falls
// (R12) floating variant floats outputs within 4 ns after strobe falls
// (R13) floating variant may drive again right after write end
// (R14) select and strobe rising together keeps outputs floating
// (R15) write timing measured from last valid to first changing address
// (R16) memory is 4096 words of 4 bits, separate data paths
// (R17) select high means standby with outputs floating
// (R18) write happens in overlap of select and strobe low
// (R19) select low, strobe high drives addressed word
`include "asrc_defs.svh"
module asrc_host
   import asrc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [11:0] req_addr,
   input wire logic [3:0] req_wdata,
   output logic req_ready,
   output logic rsp_valid,
   output logic [3:0] rsp_rdata,
   output logic [11:0] addr_in,
   output logic [3:0] wdata_in,
   output logic sel_n,
   output logic wstrobe_n,
   input wire logic [3:0] rdata_out
);
   logic rst_s1_r, rst_n_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   asrc_state_t state_r, state_nxt;
   logic tload;
   logic [`ASRC_CNT_W-1:0] tcount;
   logic tdone;

   asrc_timer u_timer (
      .clk(clk),
      .rst_n(rst_n_r),
      .load(tload),
      .count(tcount),
      .done(tdone)
   );

   function automatic logic rd_take(input asrc_state_t s, input logic d);
      rd_take = (s == ASRC_RWAIT) && d;
   endfunction

   function automatic logic [`ASRC_CNT_W-1:0] cyc(input int n);
      cyc = (n < 1) ? 3'h1 : n[`ASRC_CNT_W-1:0];
   endfunction

   always_comb begin
      state_nxt = state_r;
      tload = 1'b0;
      tcount = 3'h0;
      case (state_r)
         ASRC_IDLE: begin
            if (req_valid) begin
               tload = 1'b1;
               if (req_write) begin
                  state_nxt = ASRC_WSET;
                  // the setup cycle counts down with the strobe length
                  tcount = cyc(`ASRC_WPULSE_CYC); // see (R6)
               end else begin
                  state_nxt = ASRC_RSEL;
                  tcount = cyc(`ASRC_ACCESS_CYC); // see (R1)
               end
            end
         end
         ASRC_RSEL: state_nxt = ASRC_RWAIT;
         ASRC_RWAIT: begin
            if (tdone) begin
               state_nxt = ASRC_GAP;
               tload = 1'b1;
               tcount = cyc(`ASRC_FLOAT_CYC); // see (R4)
            end
         end
         ASRC_WSET: begin
            state_nxt = ASRC_WPULSE;
         end
         ASRC_WPULSE: begin
            if (tdone) begin
               state_nxt = ASRC_WEND;
            end
         end
         ASRC_WEND: begin
            state_nxt = ASRC_GAP;
            tload = 1'b1;
            tcount = cyc(`ASRC_FLOAT_CYC);
         end
         ASRC_GAP: begin
            if (tdone) begin
               state_nxt = ASRC_IDLE;
            end
         end
         default: state_nxt = ASRC_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= ASRC_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // address and data latched at request, held through the whole cycle
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         addr_in <= 12'h000;
         wdata_in <= 4'h0;
      end else if (state_r == ASRC_IDLE && req_valid) begin
         addr_in <= req_addr; // see (R7) (R9) (R15)
         wdata_in <= req_wdata; // see (R8)
      end
   end

   // select low during access; strobe only inside select, raised first
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sel_n <= 1'b1;
         wstrobe_n <= 1'b1;
      end else begin
         sel_n <= !(state_nxt inside {ASRC_RSEL, ASRC_RWAIT, ASRC_WSET,
                                      ASRC_WPULSE, ASRC_WEND}); // see (R17)
         wstrobe_n <= !(state_nxt == ASRC_WPULSE); // see (R18) (R9)
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= 4'h0;
      end else begin
         rsp_valid <= rd_take(state_r, tdone);
         if (rd_take(state_r, tdone)) begin
            rsp_rdata <= rdata_out; // see (R19) (R16)
         end
      end
   end

   // no request is taken before the internal reset is released
   assign req_ready = rst_n_r && (state_r == ASRC_IDLE);

   // pin protocol checks

   chk_addr_stable_sel: assert property (@(posedge clk) disable iff (!rst_n_r)
      !sel_n && $past(!sel_n) |-> addr_in == $past(addr_in)) // see (R7)
      else $error("address moved while selected");
   chk_strobe_in_sel: assert property (@(posedge clk) disable iff (!rst_n_r)
      !wstrobe_n |-> !sel_n ##1 !sel_n) // see (R18)
      else $error("strobe outside select");
   sequence s_wpulse;
      $fell(wstrobe_n) ##0 !sel_n;
   endsequence
   chk_write_width: assert property (@(posedge clk) disable iff (!rst_n_r)
      s_wpulse |-> !wstrobe_n ##1 $rose(wstrobe_n) ##0 !sel_n) // see (R6)
      else $error("write pulse width wrong");
   chk_wdata_hold: assert property (@(posedge clk) disable iff (!rst_n_r)
      !wstrobe_n |=> wdata_in == $past(wdata_in)) // see (R8)
      else $error("write data moved in write");
   // a read selects with the strobe still high one cycle later
   sequence s_read_sel;
      $fell(sel_n) ##1 (wstrobe_n && !sel_n);
   endsequence
   chk_read_access: assert property (@(posedge clk) disable iff (!rst_n_r)
      s_read_sel |=> rsp_valid && sel_n) // see (R1)
      else $error("read sampled too early or late");
   chk_deselect_gap: assert property (@(posedge clk) disable iff (!rst_n_r)
      $rose(sel_n) |-> !req_ready) // see (R4)
      else $error("no float gap after deselect");
   chk_addr_change: assert property (@(posedge clk) disable iff (!rst_n_r)
      $changed(addr_in) |-> wstrobe_n || sel_n) // see (R9)
      else $error("address changed during write");
   chk_ready_idle: assert property (@(posedge clk) disable iff (!rst_n_r)
      req_ready |-> sel_n && wstrobe_n) // see (R17)
      else $error("ready while selected");
   chk_rsp_one_cycle: assert property (@(posedge clk) disable iff (!rst_n_r)
      rsp_valid |=> !rsp_valid) // see (R19)
      else $error("response strobe longer than one cycle");
   sequence s_write_end;
      $rose(wstrobe_n) ##0 !sel_n;
   endsequence
   chk_select_before_end: assert property (@(posedge clk) disable iff (!rst_n_r)
      s_write_end |-> $past(!sel_n, 2)) // see (R6)
      else $error("select too short before write end");
   chk_addr_through_write: assert property (@(posedge clk) disable iff (!rst_n_r)
      s_write_end |-> $stable(addr_in) && $past(addr_in, 2) == addr_in) // see (R7) (R15)
      else $error("address not held through write");
   chk_wdata_setup: assert property (@(posedge clk) disable iff (!rst_n_r)
      s_write_end |-> $stable(wdata_in)) // see (R8)
      else $error("write data not set before write end");
   chk_strobe_first: assert property (@(posedge clk) disable iff (!rst_n_r)
      $rose(sel_n) |-> wstrobe_n && $past(wstrobe_n)) // see (R14)
      else $error("select rose with or before strobe");
   chk_float_gap: assert property (@(posedge clk) disable iff (!rst_n_r)
      $rose(sel_n) |=> sel_n) // see (R4) (R17)
      else $error("reselected without float gap");
   chk_strobe_after_sel: assert property (@(posedge clk) disable iff (!rst_n_r)
      $fell(wstrobe_n) |-> $past(!sel_n)) // see (R9)
      else $error("strobe fell before select");
   chk_take_addr: assert property (@(posedge clk) disable iff (!rst_n_r)
      req_ready && req_valid |=> addr_in == $past(req_addr)) // see (R7)
      else $error("address not latched at take");
   chk_sel_on_take: assert property (@(posedge clk) disable iff (!rst_n_r)
      req_ready && req_valid |=> !sel_n && wstrobe_n) // see (R18) (R19)
      else $error("select not asserted after take");
endmodule // asrc_host

//--- tb/asrc_mem_model.sv
module asrc_mem_model
   import asrc_pkg::*;
(
   input wire logic [11:0] addr_in,
   input wire logic [3:0] wdata_in,
   input wire logic sel_n,
   input wire logic wstrobe_n,
   output logic [3:0] rdata_out
);
   timeunit 1ns;
   timeprecision 100ps;
   asrc_data_t mem [0:4095];
   initial rdata_out = 4'h5;
   // the write lands at whichever of select or strobe rises first
   always @(posedge wstrobe_n or posedge sel_n) begin
      if (!(sel_n && wstrobe_n)) mem[addr_in] = wdata_in;
   end
   // released outputs show the inverse of the last value, never a stale match
   always @(sel_n, wstrobe_n, addr_in, wdata_in) begin
      if (sel_n) rdata_out <= #6 ~rdata_out;
      else if (!wstrobe_n) rdata_out <= #10 wdata_in;
      else rdata_out <= #10 mem[addr_in];
   end
endmodule // asrc_mem_model

//--- tb/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import asrc_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
   asrc_addr_t req_addr = 12'h000;
   asrc_data_t req_wdata = 4'h0;
   logic req_ready, rsp_valid, sel_n, wstrobe_n;
   logic [3:0] rsp_rdata, wdata_in, rdata_out;
   logic [11:0] addr_in;
   int fail_count = 0, checks = 0, cyc = 0;
   asrc_host i_asrc_host (.clk(clk), .rstn(rstn), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .addr_in(addr_in), .wdata_in(wdata_in), .sel_n(sel_n),
      .wstrobe_n(wstrobe_n), .rdata_out(rdata_out));
   asrc_mem_model i_asrc_mem_model (.addr_in(addr_in), .wdata_in(wdata_in),
      .sel_n(sel_n), .wstrobe_n(wstrobe_n), .rdata_out(rdata_out));
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         $display("[FAIL] %0t run did not finish", $time);
         stop_test();
      end
   end
   task automatic cmp(input logic [11:0] got, input logic [11:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // one request; checks the pin walk cycle by cycle, returns read data
   task automatic xfer(input logic w, input asrc_addr_t a, input asrc_data_t d,
                       output asrc_data_t q);
      logic [4:0] sel_e, stb_e;
      sel_e = w ? 5'b11000 : 5'b11100;
      stb_e = w ? 5'b11101 : 5'b11111;
      q = 4'h0;
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      do @(posedge clk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      for (int k = 1; k <= 5; k++) begin
         @(negedge clk);
         cmp(12'(sel_n), 12'(sel_e[k-1]), "select");
         cmp(12'(wstrobe_n), 12'(stb_e[k-1]), "strobe");
         cmp(12'(req_ready), 12'(!w && k == 5), "ready");
         if (k < 4) cmp(addr_in, a, "address");
         if (w && k < 4) cmp(12'(wdata_in), 12'(d), "write data");
         cmp(12'(rsp_valid), 12'(!w && k == 3), "response strobe");
         if (!w && k == 3) q = rsp_rdata;
      end
      @(posedge clk);
   endtask
   task automatic t_fill_and_read;
      asrc_data_t q;
      for (int i = 0; i < 16; i++) xfer(1'b1, 12'(i * 273), 4'(i), q);
      for (int i = 15; i >= 0; i--) begin
         xfer(1'b0, 12'(i * 273), 4'h0, q);
         cmp(12'(q), 12'(i), "read back");
      end
   endtask
   task automatic t_overwrite_edges;
      asrc_data_t q;
      xfer(1'b1, 12'hfff, 4'h3, q);
      xfer(1'b1, 12'h000, 4'hc, q);
      xfer(1'b1, 12'hfff, 4'ha, q);
      xfer(1'b0, 12'hfff, 4'h0, q);
      cmp(12'(q), 12'h00a, "overwritten word");
      xfer(1'b0, 12'h000, 4'h0, q);
      cmp(12'(q), 12'h00c, "neighbour kept");
   endtask
   task automatic stop_test;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      cmp(12'(sel_n), 12'h001, "select idle after reset");
      cmp(12'(req_ready), 12'h000, "ready held in reset");
      @(posedge clk);
      t_fill_and_read();
      t_overwrite_edges();
      stop_test();
   end
endmodule // tb
